// ---- baud_counter.sv ----
// Purpose: reloadable down counter pacing the bus
// Assumes: load and run come from logic on pclk
// Notes:   stops at zero until loaded again
`timescale 1ns/100ps
`default_nettype none
module baud_counter #(
  parameter int TICK_CYCLES = i2c_seq_pkg::BAUD_TICK_CYCLES
) (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       load,
  input  wire logic       run,
  input  wire logic [6:0] reload_value,
  // status
  output logic            zero
);
  typedef struct packed {
    logic [3:0] pre;
    logic [6:0] cnt;
  } baud_t;

  baud_t s_r;
  baud_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (load)
    begin
      s_nxt.cnt = reload_value;
      s_nxt.pre = 4'h0;
    end
    else if (run && s_r.cnt != 7'h00)
    begin
      if (s_r.pre == 4'(TICK_CYCLES - 1))
      begin
        s_nxt.pre = 4'h0;
        s_nxt.cnt = s_r.cnt - 7'h01;
      end
      else
        s_nxt.pre = s_r.pre + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign zero = (s_r.cnt == 7'h00);
endmodule
`default_nettype wire

// ---- i2c_master_sequencer.sv ----
// Purpose: i2c master sequencing with APB register access
// Assumes: open-drain pins, enable low pulls the line low
// Notes:   one wait state on every APB access
`timescale 1ns/100ps
`default_nettype none
module i2c_master_sequencer (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial clock pin
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_n,
  // serial data pin
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n
);
  typedef enum logic [4:0] {
    IDLE, START_WAIT, START_HOLD,
    RS_LOW, RS_SDA, RS_REL, RS_HIGH, RS_HOLD,
    TX_LOW, TX_REL, TX_HIGH,
    RX_LOW, RX_REL, RX_HIGH,
    ACK_LOW, ACK_REL, ACK_HIGH,
    SP_LOW, SP_REL, SP_HIGH, SP_SDA, SP_END
  } seq_state_t;

  typedef struct packed {
    seq_state_t  st;
    logic [5:0]  ctl;
    logic        ack_rcvd;
    logic        bf;
    logic        start_seen;
    logic        stop_seen;
    logic        write_collision_flag;
    logic        ovf;
    logic        bcol;
    logic        evt;
    logic [7:0]  tbuf;
    logic [7:0]  shift;
    logic [6:0]  reload;
    logic [3:0]  bitcnt;
    logic        last_rx;
    logic [3:0]  wage;
    logic        sda_prev;
    logic        scl_oe_n;
    logic        sda_oe_n;
    logic        scl_out;
    logic        sda_out;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } seq_t;

  seq_t        s_r;
  seq_t        s_nxt;
  logic [1:0]  pins_s;
  logic        scl_s;
  logic        sda_s;
  logic        b_load;
  logic        b_run;
  logic        b_zero;
  logic        acc;
  logic        setup_acc;
  logic        wr;
  logic        rd;
  logic        tb_wr;
  logic        collide;
  logic        mapped;
  logic [31:0] rdw;

  pin_sync #(
    .WIDTH (2)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({scl_in, sda_in}),
    .dout    (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  baud_counter #(
    .TICK_CYCLES (i2c_seq_pkg::BAUD_TICK_CYCLES)
  ) u_baud (
    .pclk         (pclk),
    .presetn      (presetn),
    .load         (b_load),
    .run          (b_run),
    .reload_value (s_r.reload),
    .zero         (b_zero)
  );

  always_comb
  begin
    s_nxt     = s_r;
    b_load    = 1'b0;
    b_run     = 1'b0;
    collide   = 1'b0;
    acc       = psel & penable & s_r.pready;
    setup_acc = psel & penable & ~s_r.pready;
    wr        = acc & pwrite;
    rd        = acc & ~pwrite;
    tb_wr     = wr && (paddr == i2c_seq_pkg::TBUF_OFS);
    mapped    = (paddr == i2c_seq_pkg::CTRL_OFS) || (paddr == i2c_seq_pkg::STATUS_OFS) ||
                (paddr == i2c_seq_pkg::TBUF_OFS) || (paddr == i2c_seq_pkg::RELOAD_OFS) ||
                (paddr == i2c_seq_pkg::FLAGS_OFS);
    rdw = 32'h0000_0000;
    case (paddr)
      i2c_seq_pkg::CTRL_OFS:
      begin
        rdw[5:0] = s_r.ctl;
        rdw[i2c_seq_pkg::ACKRCV_BIT] = s_r.ack_rcvd;
      end
      i2c_seq_pkg::STATUS_OFS:
      begin
        rdw[i2c_seq_pkg::BF_BIT]    = s_r.bf;
        rdw[i2c_seq_pkg::SSEEN_BIT] = s_r.start_seen;
        rdw[i2c_seq_pkg::PSEEN_BIT] = s_r.stop_seen;
      end
      i2c_seq_pkg::TBUF_OFS:   rdw[7:0] = s_r.tbuf;
      i2c_seq_pkg::RELOAD_OFS: rdw[6:0] = s_r.reload;
      i2c_seq_pkg::FLAGS_OFS:
      begin
        rdw[i2c_seq_pkg::WRITE_COLLISION_FLAG_BIT] = s_r.write_collision_flag;
        rdw[i2c_seq_pkg::OVF_BIT]  = s_r.ovf;
        rdw[i2c_seq_pkg::BCOL_BIT] = s_r.bcol;
        rdw[i2c_seq_pkg::EVT_BIT]  = s_r.evt;
      end
      default: rdw = 32'h0000_0000;
    endcase

    // apb answer one cycle after the access phase opens
    s_nxt.pready = setup_acc;
    if (setup_acc)
    begin
      s_nxt.prdata  = rdw;
      s_nxt.pslverr = ~mapped;
    end
    else
    begin
      s_nxt.pslverr = 1'b0;
    end

    // software clears flags by writing ones; hardware sets below win
    if (wr && paddr == i2c_seq_pkg::FLAGS_OFS)
    begin
      if (pwdata[i2c_seq_pkg::WRITE_COLLISION_FLAG_BIT]) s_nxt.write_collision_flag = 1'b0;
      if (pwdata[i2c_seq_pkg::OVF_BIT])  s_nxt.ovf  = 1'b0;
      if (pwdata[i2c_seq_pkg::BCOL_BIT]) s_nxt.bcol = 1'b0;
      if (pwdata[i2c_seq_pkg::EVT_BIT])  s_nxt.evt  = 1'b0;
    end
    if (wr && paddr == i2c_seq_pkg::RELOAD_OFS)
      s_nxt.reload = pwdata[6:0];
    if (wr && paddr == i2c_seq_pkg::CTRL_OFS)
    begin
      s_nxt.ctl[i2c_seq_pkg::ACKVAL_BIT] = pwdata[i2c_seq_pkg::ACKVAL_BIT];
      if (s_r.st == IDLE)
        s_nxt.ctl[4:0] = pwdata[4:0];
    end
    if (rd && paddr == i2c_seq_pkg::TBUF_OFS && s_r.last_rx)
      s_nxt.bf = 1'b0;

    // start and stop conditions seen on the bus
    s_nxt.sda_prev = sda_s;
    if (s_r.sda_prev && !sda_s && scl_s)
    begin
      s_nxt.start_seen = 1'b1;
      s_nxt.stop_seen  = 1'b0;
    end
    if (!s_r.sda_prev && sda_s && scl_s)
    begin
      s_nxt.stop_seen  = 1'b1;
      s_nxt.start_seen = 1'b0;
    end

    if (s_r.wage != i2c_seq_pkg::WRITE_COLLISION_FLAG_WINDOW_CYCLES)
      s_nxt.wage = s_r.wage + 4'h1;
    if (tb_wr && s_r.st != IDLE)
    begin
      s_nxt.write_collision_flag = 1'b1;
      if ((s_r.st == TX_LOW || s_r.st == TX_REL || s_r.st == TX_HIGH) &&
          s_r.wage != i2c_seq_pkg::WRITE_COLLISION_FLAG_WINDOW_CYCLES)
      begin
        s_nxt.tbuf  = pwdata[7:0];
        s_nxt.shift = pwdata[7:0];
      end
    end

    case (s_r.st)
      IDLE:
      begin
        if (s_r.ctl[i2c_seq_pkg::START_BIT])
        begin
          if (scl_s && sda_s)
          begin
            b_load    = 1'b1;
            s_nxt.st  = START_WAIT;
          end
          else
            collide = 1'b1;
        end
        else if (s_r.ctl[i2c_seq_pkg::RESTART_BIT])
        begin
          s_nxt.scl_oe_n = 1'b0;
          s_nxt.st       = RS_LOW;
        end
        else if (s_r.ctl[i2c_seq_pkg::STOP_BIT])
        begin
          s_nxt.sda_oe_n = 1'b0;
          b_load         = 1'b1;
          s_nxt.st       = SP_LOW;
        end
        else if (s_r.ctl[i2c_seq_pkg::RECV_BIT])
        begin
          s_nxt.scl_oe_n = 1'b0;
          s_nxt.sda_oe_n = 1'b1;
          s_nxt.bitcnt   = 4'h0;
          s_nxt.last_rx  = 1'b1;
          b_load         = 1'b1;
          s_nxt.st       = RX_LOW;
        end
        else if (s_r.ctl[i2c_seq_pkg::ACKSEQ_BIT])
        begin
          s_nxt.scl_oe_n = 1'b0;
          s_nxt.sda_oe_n = s_r.ctl[i2c_seq_pkg::ACKVAL_BIT];
          b_load         = 1'b1;
          s_nxt.st       = ACK_LOW;
        end
        else if (tb_wr)
        begin
          s_nxt.tbuf     = pwdata[7:0];
          s_nxt.shift    = pwdata[7:0];
          s_nxt.bf       = 1'b1;
          s_nxt.wage     = 4'h0;
          s_nxt.last_rx  = 1'b0;
          s_nxt.bitcnt   = 4'h0;
          s_nxt.scl_oe_n = 1'b0;
          s_nxt.sda_oe_n = pwdata[7];
          b_load         = 1'b1;
          s_nxt.st       = TX_LOW;
        end
      end
      START_WAIT:
      begin
        b_run = 1'b1;
        if (!scl_s)
          collide = 1'b1;
        else if (!sda_s || b_zero)
        begin
          s_nxt.sda_oe_n = 1'b0;
          b_load         = 1'b1;
          s_nxt.st       = START_HOLD;
        end
      end
      START_HOLD:
      begin
        b_run = 1'b1;
        if (b_zero)
        begin
          s_nxt.ctl[i2c_seq_pkg::START_BIT] = 1'b0;
          s_nxt.evt = 1'b1;
          s_nxt.st  = IDLE;
        end
      end
      RS_LOW:
      begin
        if (!scl_s)
        begin
          b_load         = 1'b1;
          s_nxt.sda_oe_n = 1'b1;
          s_nxt.st       = RS_SDA;
        end
      end
      RS_SDA:
      begin
        b_run = 1'b1;
        if (b_zero)
        begin
          if (sda_s)
          begin
            s_nxt.scl_oe_n = 1'b1;
            s_nxt.st       = RS_REL;
          end
          else
            collide = 1'b1;
        end
      end
      RS_REL:
      begin
        if (scl_s)
        begin
          if (!sda_s)
            collide = 1'b1;
          else
          begin
            b_load   = 1'b1;
            s_nxt.st = RS_HIGH;
          end
        end
      end
      RS_HIGH:
      begin
        b_run = 1'b1;
        if (!scl_s)
          collide = 1'b1;
        else if (b_zero)
        begin
          s_nxt.sda_oe_n = 1'b0;
          b_load         = 1'b1;
          s_nxt.st       = RS_HOLD;
        end
      end
      RS_HOLD:
      begin
        b_run = 1'b1;
        if (b_zero)
        begin
          s_nxt.ctl[i2c_seq_pkg::RESTART_BIT] = 1'b0;
          s_nxt.evt = 1'b1;
          s_nxt.st  = IDLE;
        end
      end
      TX_LOW, RX_LOW, ACK_LOW, SP_LOW:
      begin
        b_run = 1'b1;
        if (b_zero)
        begin
          s_nxt.scl_oe_n = 1'b1;
          s_nxt.st = (s_r.st == TX_LOW) ? TX_REL : (s_r.st == RX_LOW) ? RX_REL :
                     (s_r.st == ACK_LOW) ? ACK_REL : SP_REL;
        end
      end
      TX_REL, RX_REL, ACK_REL, SP_REL:
      begin
        if (scl_s)
        begin
          b_load   = 1'b1;
          s_nxt.st = (s_r.st == TX_REL) ? TX_HIGH : (s_r.st == RX_REL) ? RX_HIGH :
                     (s_r.st == ACK_REL) ? ACK_HIGH : SP_HIGH;
        end
      end
      TX_HIGH:
      begin
        b_run = 1'b1;
        if (s_r.sda_oe_n && !sda_s && s_r.bitcnt < 4'h8)
          collide = 1'b1;
        else if (b_zero)
        begin
          s_nxt.scl_oe_n = 1'b0;
          if (s_r.bitcnt == 4'h8)
          begin
            s_nxt.ack_rcvd = sda_s;
            s_nxt.evt      = 1'b1;
            s_nxt.st       = IDLE;
          end
          else
          begin
            s_nxt.bitcnt = s_r.bitcnt + 4'h1;
            s_nxt.shift  = {s_r.shift[6:0], 1'b0};
            if (s_r.bitcnt == 4'h7)
            begin
              s_nxt.bf       = 1'b0;
              s_nxt.sda_oe_n = 1'b1;
            end
            else
              s_nxt.sda_oe_n = s_r.shift[6];
            b_load   = 1'b1;
            s_nxt.st = TX_LOW;
          end
        end
      end
      RX_HIGH:
      begin
        b_run = 1'b1;
        if (b_zero)
        begin
          s_nxt.scl_oe_n = 1'b0;
          s_nxt.shift    = {s_r.shift[6:0], sda_s};
          s_nxt.bitcnt   = s_r.bitcnt + 4'h1;
          if (s_r.bitcnt == 4'h7)
          begin
            s_nxt.ctl[i2c_seq_pkg::RECV_BIT] = 1'b0;
            if (s_r.bf)
              s_nxt.ovf = 1'b1;
            else
              s_nxt.tbuf = {s_r.shift[6:0], sda_s};
            s_nxt.bf  = 1'b1;
            s_nxt.evt = 1'b1;
            s_nxt.st  = IDLE;
          end
          else
          begin
            b_load   = 1'b1;
            s_nxt.st = RX_LOW;
          end
        end
      end
      ACK_HIGH:
      begin
        b_run = 1'b1;
        if (b_zero)
        begin
          s_nxt.scl_oe_n = 1'b0;
          s_nxt.ctl[i2c_seq_pkg::ACKSEQ_BIT] = 1'b0;
          s_nxt.evt = 1'b1;
          s_nxt.st  = IDLE;
        end
      end
      SP_HIGH:
      begin
        b_run = 1'b1;
        if (b_zero)
        begin
          s_nxt.sda_oe_n = 1'b1;
          s_nxt.st       = SP_SDA;
        end
      end
      SP_SDA:
      begin
        if (sda_s && scl_s)
        begin
          b_load   = 1'b1;
          s_nxt.st = SP_END;
        end
      end
      SP_END:
      begin
        b_run = 1'b1;
        if (b_zero)
        begin
          s_nxt.ctl[i2c_seq_pkg::STOP_BIT] = 1'b0;
          s_nxt.evt = 1'b1;
          s_nxt.st  = IDLE;
        end
      end
      default: s_nxt.st = IDLE;
    endcase

    if (collide)
    begin
      s_nxt.bcol     = 1'b1;
      s_nxt.ctl[4:0] = 5'h00;
      s_nxt.scl_oe_n = 1'b1;
      s_nxt.sda_oe_n = 1'b1;
      if (!s_r.last_rx)
        s_nxt.bf = 1'b0;
      s_nxt.st = IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r          <= '0;
      s_r.st       <= IDLE;
      s_r.ctl      <= i2c_seq_pkg::CTRL_RST;
      s_r.tbuf     <= i2c_seq_pkg::TBUF_RST;
      s_r.reload   <= i2c_seq_pkg::RELOAD_RST;
      s_r.wage     <= i2c_seq_pkg::WRITE_COLLISION_FLAG_WINDOW_CYCLES;
      s_r.sda_prev <= 1'b1;
      s_r.scl_oe_n <= 1'b1;
      s_r.sda_oe_n <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign prdata   = s_r.prdata;
  assign pready   = s_r.pready;
  assign pslverr  = s_r.pslverr;
  assign scl_out  = s_r.scl_out;
  assign scl_oe_n = s_r.scl_oe_n;
  assign sda_out  = s_r.sda_out;
  assign sda_oe_n = s_r.sda_oe_n;
endmodule
`default_nettype wire

// ---- i2c_seq_pkg.sv ----
// Purpose: shared constants for the i2c master sequencer
// Assumes: pclk at 40 MHz, instruction cycle of four pclk periods
// Notes:   register map sits on APB, one aligned 32-bit word each
package i2c_seq_pkg;
  localparam int CLK_PERIOD_NS      = 25;
  localparam int CLKS_PER_TCY       = 4;
  localparam int BAUD_DECS_PER_TCY  = 2;
  localparam int BAUD_TICK_CYCLES   = CLKS_PER_TCY / BAUD_DECS_PER_TCY;
  localparam int WRITE_COLLISION_FLAG_WINDOW_TCY    = 2;
  localparam logic [3:0] WRITE_COLLISION_FLAG_WINDOW_CYCLES = 4'(WRITE_COLLISION_FLAG_WINDOW_TCY * CLKS_PER_TCY);

  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] TBUF_OFS   = 8'h08;
  localparam logic [7:0] RELOAD_OFS = 8'h0c;
  localparam logic [7:0] FLAGS_OFS  = 8'h10;

  localparam int START_BIT   = 0;
  localparam int RESTART_BIT = 1;
  localparam int STOP_BIT    = 2;
  localparam int RECV_BIT    = 3;
  localparam int ACKSEQ_BIT  = 4;
  localparam int ACKVAL_BIT  = 5;
  localparam int ACKRCV_BIT  = 6;

  localparam int BF_BIT      = 0;
  localparam int SSEEN_BIT   = 3;
  localparam int PSEEN_BIT   = 4;

  localparam int WRITE_COLLISION_FLAG_BIT    = 0;
  localparam int OVF_BIT     = 1;
  localparam int BCOL_BIT    = 2;
  localparam int EVT_BIT     = 3;

  localparam logic [6:0] RELOAD_RST = 7'h09;
  localparam logic [7:0] TBUF_RST   = 8'h00;
  localparam logic [5:0] CTRL_RST   = 6'h00;
endpackage

// ---- i2c_target_model.sv ----
// Purpose: behavioural i2c target facing the sequencer
// Assumes: lines given as resolved wire levels
// Notes:   arm restarts the bit count of one byte
`timescale 1ns/100ps
`default_nettype none
module i2c_target_model (
  // bus
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            scl_pn,
  output logic            sda_pn,
  // control
  input  wire logic       arm,
  input  wire logic       rd_mode,
  input  wire logic       ack_en,
  input  wire logic       hold,
  input  wire logic       stretch,
  input  wire logic [7:0] tx,
  output logic      [7:0] got
);
  int   rc;
  logic drv;
  logic sclk;
  assign sda_pn = drv & ~hold;
  assign scl_pn = sclk & ~hold;
  initial
  begin
    rc = 9;
    drv = 1'b1;
    sclk = 1'b1;
    got = 8'h00;
  end
  always @(posedge arm)
  begin
    rc = 0;
    drv = rd_mode ? tx[7] : 1'b1;
  end
  // capture on rising scl, count clocks
  always @(posedge scl)
    if (rc < 9)
    begin
      if (rc < 8)
        got = {got[6:0], sda};
      rc = rc + 1;
    end
  // data and ack change while scl low
  always @(negedge scl)
  begin
    if (rd_mode)
      drv = (rc < 8) ? tx[7 - rc] : 1'b1;
    else
      drv = !(rc == 8 && ack_en);
    if (stretch)
    begin
      sclk = 1'b0;
      #600 sclk = 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- pin_sync.sv ----
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to pclk
// Notes:   first stage feeds only the second
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_t;

  sync_t s_r;
  sync_t s_nxt;

  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.meta = din;
    s_nxt.sync = s_r.meta;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '1;
    else
      s_r <= s_nxt;
  end

  assign dout = s_r.sync;
endmodule
`default_nettype wire

// ---- seq_asserts.sv ----
// Purpose: port checks for the i2c sequencer
// Assumes: pull-ups on both lines
// Notes:   reload value tracked from apb writes
`timescale 1ns/100ps
`default_nettype none
module seq_asserts (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic        scl_in,
  input wire logic        scl_out,
  input wire logic        scl_oe_n,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_n
);
  logic [6:0] rld_r;
  logic [8:0] hi_r;
  logic [8:0] lo_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      rld_r <= i2c_seq_pkg::RELOAD_RST;
      hi_r  <= 9'h000;
      lo_r  <= 9'h000;
    end
    else
    begin
      if (psel && penable && pready && pwrite && paddr == i2c_seq_pkg::RELOAD_OFS)
        rld_r <= pwdata[6:0];
      hi_r <= scl_in ? hi_r + {8'h00, ~&hi_r} : 9'h000;
      lo_r <= !scl_oe_n ? lo_r + {8'h00, ~&lo_r} : 9'h000;
    end
  apb_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  idle_ready_a: assert property (!(psel && penable) |-> !pready)
    else $error("pready without access");
  outs_low_a: assert property (!scl_out && !sda_out)
    else $error("pin output data not low");
  scl_high_a: assert property ($fell(scl_oe_n) |-> hi_r >= {1'b0, rld_r, 1'b0})
    else $error("scl high phase too short");
  scl_low_a: assert property ($rose(scl_oe_n) |-> lo_r >= {1'b0, rld_r, 1'b0})
    else $error("scl low phase too short");
  start_edge_a: assert property ($fell(sda_oe_n) && scl_oe_n |-> scl_in)
    else $error("sda pulled while scl low and released");
endmodule
bind i2c_master_sequencer seq_asserts chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n));
`default_nettype wire

// ---- testbench.sv ----
// Purpose: self-checking bench for the i2c sequencer
// Assumes: pull-ups on both lines, one target
// Notes:   random bytes from a fixed seed
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam logic [7:0] cta = i2c_seq_pkg::CTRL_OFS;
  localparam logic [7:0] sta = i2c_seq_pkg::STATUS_OFS;
  localparam logic [7:0] bfa = i2c_seq_pkg::TBUF_OFS;
  localparam logic [7:0] fla = i2c_seq_pkg::FLAGS_OFS;
  localparam logic [31:0] all = 32'hffffffff;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        scl_out, scl_oe_n, sda_out, sda_oe_n, scl_pn, sda_pn;
  logic        arm, rd_mode, ack_en, hold, stretch;
  logic [7:0]  paddr, tx, got, b, b2, keep;
  logic [6:0]  rl;
  logic [31:0] pwdata, prdata, q;
  int          mismatches, check_count, cyc;
  wire         scl_w = scl_oe_n & scl_pn;
  wire         sda_w = sda_oe_n & sda_pn;
  i2c_master_sequencer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
  i2c_target_model tgt (.scl(scl_w), .sda(sda_w), .scl_pn(scl_pn), .sda_pn(sda_pn), .arm(arm),
    .rd_mode(rd_mode), .ack_en(ack_en), .hold(hold), .stretch(stretch), .tx(tx), .got(got));
  function automatic logic [31:0] bt(input int n);
    return 32'h1 << n;
  endfunction
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q & m);
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    apb(1'b0, a, 32'h0);
    while ((q & m) !== v)
      apb(1'b0, a, 32'h0);
  endtask
  task automatic arm_tgt;
    @(posedge pclk);
    arm <= 1'b1;
    @(posedge pclk);
    arm <= 1'b0;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      mismatches++;
      end_sim();
    end
  end
  initial
  begin
    {presetn, psel, penable, pwrite, arm, rd_mode, ack_en, hold, stretch} = 9'h000;
    paddr = 8'h00;
    pwdata = 32'h0;
    tx = 8'h00;
    void'($urandom(36));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(i2c_seq_pkg::RELOAD_OFS, all, {25'h0, i2c_seq_pkg::RELOAD_RST}, "reload");
    rd_chk(cta, all, 32'h0, "ctrl");
    rd_chk(8'h20, all, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, err});
    rl = 7'($urandom_range(12, 3));
    apb(1'b1, i2c_seq_pkg::RELOAD_OFS, {25'h0, rl});
    rd_chk(i2c_seq_pkg::RELOAD_OFS, all, {25'h0, rl}, "reload");
    $display("test registers done");
    apb(1'b1, cta, bt(i2c_seq_pkg::START_BIT));
    apb(1'b1, bfa, 32'h5a);
    apb(1'b1, cta, bt(i2c_seq_pkg::RECV_BIT) | bt(i2c_seq_pkg::RESTART_BIT));
    poll(cta, 32'h3f, 32'h0);
    chk("sda", 32'h0, {31'h0, sda_w});
    rd_chk(sta, all, bt(i2c_seq_pkg::SSEEN_BIT), "status");
    rd_chk(bfa, all, 32'h0, "buffer");
    rd_chk(fla, all, 32'h9, "flags");
    apb(1'b1, fla, 32'hf);
    $display("test start done");
    for (int i = 0; i < 3; i++)
    begin
      b = 8'($urandom);
      b2 = 8'($urandom);
      rd_mode <= 1'b0;
      ack_en <= (i != 1);
      stretch <= (i == 2);
      arm_tgt();
      apb(1'b1, bfa, {24'h0, b});
      if (i == 0)
        apb(1'b1, bfa, {24'h0, b2});
      if (i == 2)
      begin
        rd_chk(sta, bt(i2c_seq_pkg::BF_BIT), bt(i2c_seq_pkg::BF_BIT), "full");
        repeat (20) @(posedge pclk);
        apb(1'b1, bfa, {24'h0, b2});
      end
      poll(fla, 32'h8, 32'h8);
      // early rewrite: first bit already on the line, the rest from the new byte
      chk("byte", {24'h0, (i == 0) ? {b[7], b2[6:0]} : b}, {24'h0, got});
      rd_chk(cta, all, (i == 1) ? bt(i2c_seq_pkg::ACKRCV_BIT) : 32'h0, "ack");
      rd_chk(sta, 32'h1, 32'h0, "full");
      rd_chk(fla, 32'h1, (i == 1) ? 32'h0 : 32'h1, "write_collision_flag");
      apb(1'b1, fla, 32'hf);
    end
    stretch <= 1'b0;
    $display("test transmit done");
    for (int i = 0; i < 3; i++)
    begin
      b = 8'($urandom);
      rd_mode <= 1'b1;
      tx <= b;
      arm_tgt();
      apb(1'b1, cta, bt(i2c_seq_pkg::RECV_BIT));
      if (i == 0)
        apb(1'b1, bfa, 32'h33);
      poll(cta, bt(i2c_seq_pkg::RECV_BIT), 32'h0);
      rd_chk(sta, 32'h1, 32'h1, "full");
      if (i == 0)
      begin
        rd_chk(bfa, all, {24'h0, b}, "rx byte");
        rd_chk(sta, 32'h1, 32'h0, "full");
      end
      if (i == 1)
        keep = b;
    end
    rd_chk(fla, 32'h3, 32'h3, "ovf write_collision_flag");
    rd_chk(bfa, all, {24'h0, keep}, "kept");
    apb(1'b1, fla, 32'hf);
    apb(1'b1, cta, bt(i2c_seq_pkg::ACKSEQ_BIT));
    poll(cta, bt(i2c_seq_pkg::ACKSEQ_BIT), 32'h0);
    rd_chk(fla, all, 32'h8, "event");
    apb(1'b1, fla, 32'hf);
    $display("test receive done");
    apb(1'b1, cta, bt(i2c_seq_pkg::RESTART_BIT));
    apb(1'b1, bfa, 32'h11);
    poll(cta, bt(i2c_seq_pkg::RESTART_BIT), 32'h0);
    rd_chk(fla, all, 32'h9, "flags");
    rd_chk(sta, 32'h8, 32'h8, "start");
    apb(1'b1, cta, bt(i2c_seq_pkg::STOP_BIT));
    poll(cta, bt(i2c_seq_pkg::STOP_BIT), 32'h0);
    rd_chk(sta, 32'h10, 32'h10, "stop");
    chk("lines", 32'h3, {30'h0, scl_w, sda_w});
    apb(1'b1, fla, 32'hf);
    hold <= 1'b1;
    apb(1'b1, cta, bt(i2c_seq_pkg::START_BIT));
    poll(cta, 32'h1, 32'h0);
    rd_chk(fla, 32'h4, 32'h4, "bcol");
    hold <= 1'b0;
    $display("test conditions done");
    end_sim();
  end
endmodule
`default_nettype wire
